// [design/hs_defines.svh]
// Offsets-free constants: config codes, timing figures and derived counts
`ifndef HS_DEFINES_SVH
`define HS_DEFINES_SVH

// Per-output source configuration codes
`define CFG_OFF         3'h0
`define CFG_ON          3'h1
`define CFG_TIMER1      3'h2
`define CFG_TIMER2      3'h3
`define CFG_PWM1        3'h4
`define CFG_PWM2        3'h5

// Period select codes per generator
`define PER_200HZ       1'h0
`define PER_400HZ       1'h1

// Clock and timing figures
`define CLK_PERIOD_NS   10
`define PWM_STEPS       256
`define PWM_200_PER_US  5000
`define PWM_400_PER_US  2500
`define OL_FILT_US      64
`define OC_FILT_US      16

// Derived cycle counts
`define PWM_200_STEP_CYC ((`PWM_200_PER_US * 1000) / (`CLK_PERIOD_NS * `PWM_STEPS))
`define PWM_400_STEP_CYC ((`PWM_400_PER_US * 1000) / (`CLK_PERIOD_NS * `PWM_STEPS))
`define OL_FILT_CYC      ((`OL_FILT_US * 1000) / `CLK_PERIOD_NS)
`define OC_FILT_CYC      ((`OC_FILT_US * 1000) / `CLK_PERIOD_NS)

`endif

// [design/hs_pkg.sv]
// Types shared by the high-side switch control and its PWM generator
package hs_pkg;

    // Operating mode of the surrounding chip
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } sbc_mode_t;

    // Source configuration write, one strobe per output
    typedef struct packed {
        logic [3:0] we;
        logic [2:0] val;
    } cfg_wr_t;

    // Duty and period writes for the two generators
    typedef struct packed {
        logic [1:0] duty_we;
        logic [7:0] duty;
        logic       per_we;
        logic [1:0] per;
    } pwm_wr_t;

    // Analog comparator results per output
    typedef struct packed {
        logic [3:0] under_ol;
        logic [3:0] over_oc;
    } sense_t;

    // PWM generator state
    typedef struct packed {
        logic [15:0] pre;
        logic [7:0]  step;
        logic        out;
    } pwm_state_t;

    // Main control state
    typedef struct packed {
        logic [3:0][2:0]  cfg;
        logic [1:0][7:0]  duty;
        logic [1:0]       per;
        logic [3:0]       ol_flag;
        logic [3:0]       oc_flag;
        logic [3:0][15:0] ol_cnt;
        logic [3:0][15:0] oc_cnt;
        logic [3:0]       hs_on;
        logic [3:0]       oc_evt;
    } hs_state_t;

endpackage

// [design/pwm_gen.sv]
// One 8-bit PWM generator with 256 steps per period
`timescale 1ns/1ps
`default_nettype none
`include "hs_defines.svh"

module pwm_gen #(
    parameter logic [15:0] STEP_200 = 16'(`PWM_200_STEP_CYC),
    parameter logic [15:0] STEP_400 = 16'(`PWM_400_STEP_CYC)
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] duty_i,
    input  wire logic       per_sel_i,
    output logic            pwm_o
);
    import hs_pkg::*;

    pwm_state_t s_q;
    pwm_state_t s_d;
    logic [15:0] lim;

    // Prescaler and step counter, output high below duty
    always_comb begin
        s_d = s_q;
        lim = (per_sel_i == `PER_400HZ) ? STEP_400 : STEP_200;
        if (s_q.pre >= lim - 16'h0001) begin
            s_d.pre  = 16'h0000;
            s_d.step = s_q.step + 8'h01;
        end else begin
            s_d.pre = s_q.pre + 16'h0001;
        end
        s_d.out = (s_q.step < duty_i);
    end

    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pwm_o = s_q.out;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    pwm_zero_a: assert property ($past(duty_i) == 8'h00 |-> !pwm_o)
        else $error("pwm high with zero duty");
    pwm_full_a: assert property ($past(duty_i) == 8'hFF
                                 && $past(s_q.step) != 8'hFF |-> pwm_o)
        else $error("pwm low below duty");
    pwm_step_a: assert property (s_q.pre == 16'h0000 && $past(s_q.pre) != 16'h0000
                                 |-> s_q.step == 8'($past(s_q.step) + 8'h01))
        else $error("step did not advance at prescaler wrap");
endmodule
`default_nettype wire

// [design/high_side_switch_pwm_control.sv]
// Control of four high-side outputs: sources, PWM, filters and mode handling
`timescale 1ns/1ps
`default_nettype none
`include "hs_defines.svh"

module high_side_switch_pwm_control #(
    parameter logic [15:0] OL_FILT_CYC = 16'(`OL_FILT_CYC),
    parameter logic [15:0] OC_FILT_CYC = 16'(`OC_FILT_CYC),
    parameter logic [15:0] STEP_200    = 16'(`PWM_200_STEP_CYC),
    parameter logic [15:0] STEP_400    = 16'(`PWM_400_STEP_CYC)
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire hs_pkg::sbc_mode_t mode_i,
    input  wire hs_pkg::cfg_wr_t  cfg_wr_i,
    input  wire hs_pkg::pwm_wr_t  pwm_wr_i,
    input  wire hs_pkg::sense_t   sense_i,
    input  wire logic             supply_off_i,
    input  wire logic             timer1_i,
    input  wire logic             timer2_i,
    input  wire logic [3:0]       ol_clear_i,
    input  wire logic [3:0]       oc_clear_i,
    output logic [3:0]            hs_on_o,
    output logic [3:0]            open_load_status_reg_o,
    output logic [3:0]            oc_flag_o,
    output logic [3:0]            oc_shutdown_o,
    output logic [3:0][2:0]       cfg_o,
    output logic [1:0]            pwm_o
);
    import hs_pkg::*;

    hs_state_t  s_q;
    hs_state_t  s_d;
    logic [1:0] pwm;
    logic       run;
    logic       cfg_ok;
    logic       src;
    logic       ol_cond;
    logic       oc_cond;

    // Two generators, each with its own duty and period
    for (genvar g = 0; g < 2; g++) begin : g_pwm
        pwm_gen #(
            .STEP_200 (STEP_200),
            .STEP_400 (STEP_400)
        ) u_pwm (
            .clk_i     (clk_i),
            .nrst_i    (nrst_i),
            .duty_i    (s_q.duty[g]),
            .per_sel_i (s_q.per[g]),
            .pwm_o     (pwm[g])
        );
    end

    // Configuration, filters, flags and output drive
    always_comb begin
        s_d        = s_q;
        s_d.oc_evt = '0;
        src        = 1'b0;
        ol_cond    = 1'b0;
        oc_cond    = 1'b0;
        run        = (mode_i == MODE_NORMAL) || (mode_i == MODE_STOP)
                     || (mode_i == MODE_SLEEP);
        cfg_ok     = (mode_i == MODE_NORMAL);
        if (cfg_ok) begin
            for (int g = 0; g < 2; g++) begin
                if (pwm_wr_i.duty_we[g]) begin
                    s_d.duty[g] = pwm_wr_i.duty;
                end
            end
            if (pwm_wr_i.per_we) begin
                s_d.per = pwm_wr_i.per;
            end
        end
        for (int i = 0; i < 4; i++) begin
            // Writes only in normal mode; low-power keeps the setting
            if (cfg_ok && cfg_wr_i.we[i]) begin
                s_d.cfg[i] = cfg_wr_i.val;
            end
            // Open-load filter, runs in every active mode
            ol_cond = s_q.hs_on[i] && sense_i.under_ol[i];
            if (!ol_cond) begin
                s_d.ol_cnt[i] = 16'h0000;
            end else if (s_q.ol_cnt[i] != OL_FILT_CYC - 16'h0001) begin
                s_d.ol_cnt[i] = s_q.ol_cnt[i] + 16'h0001;
            end
            if (ol_clear_i[i]) begin
                s_d.ol_flag[i] = 1'b0;
            end
            if (ol_cond && s_q.ol_cnt[i] == OL_FILT_CYC - 16'h0001) begin
                s_d.ol_flag[i] = 1'b1;
            end
            // Overcurrent filter and shutdown
            oc_cond = s_q.hs_on[i] && sense_i.over_oc[i];
            if (!oc_cond) begin
                s_d.oc_cnt[i] = 16'h0000;
            end else if (s_q.oc_cnt[i] != OC_FILT_CYC - 16'h0001) begin
                s_d.oc_cnt[i] = s_q.oc_cnt[i] + 16'h0001;
            end
            if (oc_clear_i[i]) begin
                s_d.oc_flag[i] = 1'b0;
            end
            if (oc_cond && s_q.oc_cnt[i] == OC_FILT_CYC - 16'h0001) begin
                s_d.oc_flag[i] = 1'b1;
                s_d.oc_evt[i]  = 1'b1;
                s_d.cfg[i]     = `CFG_OFF;
            end
            // Restart and fail-safe drop every configuration
            if (!run) begin
                s_d.cfg[i] = `CFG_OFF;
            end
            // Source selection from the new configuration
            case (s_d.cfg[i])
                `CFG_ON:     src = 1'b1;
                `CFG_TIMER1: src = timer1_i;
                `CFG_TIMER2: src = timer2_i;
                `CFG_PWM1:   src = pwm[0];
                `CFG_PWM2:   src = pwm[1];
                default:     src = 1'b0;
            endcase
            s_d.hs_on[i] = run && !supply_off_i && src;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign hs_on_o                = s_q.hs_on;
    assign open_load_status_reg_o = s_q.ol_flag;
    assign oc_flag_o              = s_q.oc_flag;
    assign oc_shutdown_o          = s_q.oc_evt;
    assign cfg_o                  = s_q.cfg;
    assign pwm_o                  = pwm;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Per-output checks
    for (genvar i = 0; i < 4; i++) begin : g_chk
        // Open-load flag: sticky, filtered, clearable, no effect on drive
        ol_sticky_a: assert property (s_q.ol_flag[i] && !ol_clear_i[i] |=> s_q.ol_flag[i])
            else $error("open-load flag dropped without clear");
        ol_clear_a: assert property (ol_clear_i[i] && !sense_i.under_ol[i]
                                     |=> !s_q.ol_flag[i])
            else $error("open-load flag kept after clear");
        ol_filter_a: assert property ($rose(s_q.ol_flag[i])
                                      |-> $past(s_q.ol_cnt[i]) == OL_FILT_CYC - 16'h0001)
            else $error("open-load flag set before filter time");
        ol_keep_on_a: assert property (s_q.hs_on[i] && sense_i.under_ol[i]
                                       && !sense_i.over_oc[i] && s_q.cfg[i] == `CFG_ON
                                       && cfg_ok && !cfg_wr_i.we[i] && !supply_off_i
                                       |=> s_q.hs_on[i])
            else $error("open load switched output off");
        // Overcurrent: filtered, one-cycle event, config dropped
        oc_off_a: assert property (s_q.oc_evt[i] |-> s_q.cfg[i] == `CFG_OFF
                                   && !s_q.hs_on[i] && s_q.oc_flag[i])
            else $error("overcurrent did not clear config");
        oc_filter_a: assert property ($rose(s_q.oc_evt[i])
                                      |-> $past(sense_i.over_oc[i] && s_q.hs_on[i])
                                      && $past(s_q.oc_cnt[i]) == OC_FILT_CYC - 16'h0001)
            else $error("overcurrent shutdown before filter time");
        oc_pulse_a: assert property (s_q.oc_evt[i] |=> !s_q.oc_evt[i])
            else $error("shutdown event longer than one cycle");
        oc_restart_a: assert property (!sense_i.over_oc[i] |=> s_q.oc_cnt[i] == 16'h0000)
            else $error("overcurrent filter not restarted");
        // Configuration and drive source
        cfg_write_a: assert property (cfg_ok && cfg_wr_i.we[i] && !s_d.oc_evt[i]
                                      |=> s_q.cfg[i] == $past(cfg_wr_i.val))
            else $error("config write in normal mode lost");
        cfg_lock_a: assert property ((mode_i == MODE_STOP || mode_i == MODE_SLEEP)
                                     && !s_d.oc_evt[i] |=> $stable(s_q.cfg[i]))
            else $error("config changed in low-power mode");
        cfg_off_a: assert property (s_d.cfg[i] == `CFG_OFF |=> !s_q.hs_on[i])
            else $error("output on with config off");
        pwm_drive_a: assert property (s_d.cfg[i] == `CFG_PWM1 && run && !supply_off_i
                                      |=> s_q.hs_on[i] == $past(pwm[0]))
            else $error("output not following generator one");
        pwm2_drive_a: assert property (s_d.cfg[i] == `CFG_PWM2 && run && !supply_off_i
                                       |=> s_q.hs_on[i] == $past(pwm[1]))
            else $error("output not following generator two");
    end

    // Mode and supply forcing
    fail_off_a: assert property (mode_i == MODE_RESTART || mode_i == MODE_FAILSAFE
                                 |=> s_q.hs_on == 4'h0 && s_q.cfg == '0)
        else $error("outputs on in restart or fail-safe");
    supply_off_a: assert property (supply_off_i |=> s_q.hs_on == 4'h0)
        else $error("output on during supply shutdown");

    // Main scenarios
    ol_seen_c: cover property ($rose(s_q.ol_flag[0]));
    oc_seen_c: cover property ($rose(s_q.oc_evt[1]));
    pwm_on_c:  cover property (s_q.cfg[3] == `CFG_PWM2 && $rose(s_q.hs_on[3]));
    stop_on_c: cover property (mode_i == MODE_STOP && s_q.hs_on[0]);
    fs_off_c:  cover property (mode_i == MODE_FAILSAFE && s_q.cfg == '0);
endmodule
`default_nettype wire

// [verif/load_model.sv]
// Behavioural loads on the four outputs: normal, open or shorted
`timescale 1ns/1ps
`default_nettype none

module load_model (
    input  wire logic [3:0] hs_on_i,
    input  wire logic [3:0] open_i,
    input  wire logic [3:0] short_i,
    output hs_pkg::sense_t  sense_o
);
    import hs_pkg::*;

    // An off or open output carries no current, so it reads below threshold
    assign sense_o.under_ol = open_i | ~hs_on_i;
    // Only a driven short pulls current above the limit
    assign sense_o.over_oc  = short_i & hs_on_i;
endmodule
`default_nettype wire

// [verif/high_side_switch_pwm_control_tb_top.sv]
// Self-checking bench for the high-side switch control
`timescale 1ns/1ps
`default_nettype none
`include "hs_defines.svh"

module high_side_switch_pwm_control_tb_top;
    import hs_pkg::*;
    localparam int OLF = 8;
    localparam int OCF = 4;
    logic clk_i = 0, nrst_i = 0, t1 = 0, t2 = 0, sup = 0;
    sbc_mode_t mode = MODE_NORMAL;
    cfg_wr_t cw = '0;
    pwm_wr_t pw = '0;
    sense_t sn;
    logic [3:0] opn = '0, sht = '0, olc = '0, occ = '0;
    logic [3:0] hs, olf, ocf, ocs;
    logic [3:0][2:0] cfg;
    logic [1:0] pwm;
    int n_mismatch = 0, compares = 0;

    // Clock
    always #5 clk_i = ~clk_i;

    // Device with shortened counts
    high_side_switch_pwm_control #(.OL_FILT_CYC(16'(OLF)), .OC_FILT_CYC(16'(OCF)),
        .STEP_200(16'h4), .STEP_400(16'h2)) u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode), .cfg_wr_i(cw), .pwm_wr_i(pw),
        .sense_i(sn), .supply_off_i(sup), .timer1_i(t1), .timer2_i(t2),
        .ol_clear_i(olc), .oc_clear_i(occ), .hs_on_o(hs), .open_load_status_reg_o(olf),
        .oc_flag_o(ocf), .oc_shutdown_o(ocs), .cfg_o(cfg), .pwm_o(pwm));

    // Loads on the outputs
    load_model u_load (.hs_on_i(hs), .open_i(opn), .short_i(sht), .sense_o(sn));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr_cfg(input logic [3:0] we, input logic [2:0] v);
        @(posedge clk_i);
        cw <= '{we: we, val: v};
        @(posedge clk_i);
        cw <= '0;
        tick(1);
    endtask

    task automatic pulse_clr(input logic [3:0] o, input logic [3:0] c);
        @(posedge clk_i);
        olc <= o;
        occ <= c;
        @(posedge clk_i);
        olc <= '0;
        occ <= '0;
        tick(2);
    endtask

    task automatic test_open_load();
        wr_cfg(4'h1, `CFG_ON);
        chk("hs0 on", 16'h1, 16'(hs[0]));
        @(posedge clk_i) opn <= 4'h1;
        tick(OLF - 2);
        @(posedge clk_i) opn <= 4'h0;
        @(posedge clk_i) opn <= 4'h1;
        tick(OLF - 1);
        chk("ol0 early", 16'h0, 16'(olf[0]));
        tick(2);
        chk("ol0 set", 16'h1, 16'(olf[0]));
        chk("hs0 kept", 16'h1, 16'(hs[0]));
        pulse_clr(4'h1, 4'h0);
        tick(OLF);
        chk("ol0 reset", 16'h1, 16'(olf[0]));
        @(posedge clk_i) opn <= 4'h0;
        tick(OLF + 2);
        chk("ol0 sticky", 16'h1, 16'(olf[0]));
        pulse_clr(4'h1, 4'h0);
        chk("ol0 clr", 16'h0, 16'(olf));
        $display("test_open_load done");
    endtask

    task automatic test_overcurrent();
        wr_cfg(4'h2, `CFG_ON);
        // Short held one sampled cycle less than the filter
        @(posedge clk_i) sht <= 4'h2;
        tick(OCF - 2);
        @(posedge clk_i) sht <= 4'h0;
        tick(3);
        chk("oc1 glitch", 16'h2, 16'(hs & 4'h2));
        @(posedge clk_i) sht <= 4'h2;
        tick(OCF - 1);
        chk("oc1 filter", 16'h2, 16'(hs & 4'h2));
        tick(1);
        chk("oc1 pulse", 16'h1, 16'(ocs[1]));
        chk("oc1 cfg", 16'h0, 16'(cfg[1]));
        chk("oc1 off", 16'h0, 16'(hs[1]));
        chk("oc1 flag", 16'h2, 16'(ocf));
        tick(1);
        chk("oc1 pulse end", 16'h0, 16'(ocs));
        @(posedge clk_i) sht <= 4'h0;
        pulse_clr(4'h0, 4'h2);
        chk("oc1 clr", 16'h0, 16'(ocf));
        wr_cfg(4'h2, `CFG_ON);
        chk("oc1 back", 16'h2, 16'(hs & 4'h2));
        $display("test_overcurrent done");
    endtask

    task automatic test_pwm();
        int h0, h1, lag;
        logic p0, p1;
        h0 = 0;
        h1 = 0;
        lag = 0;
        @(posedge clk_i);
        pw <= '{duty_we: 2'h1, duty: 8'h03, per_we: 1'b1, per: 2'h2};
        @(posedge clk_i);
        pw <= '{duty_we: 2'h2, duty: 8'h04, per_we: 1'b0, per: 2'h2};
        @(posedge clk_i);
        pw <= '0;
        wr_cfg(4'h4, `CFG_PWM1);
        wr_cfg(4'h8, `CFG_PWM2);
        p0 = pwm[0];
        p1 = pwm[1];
        // One 200 Hz period is 256 steps of 4 cycles, two 400 Hz periods
        repeat (1024) begin
            tick(1);
            h0 += int'(pwm[0]);
            h1 += int'(pwm[1]);
            if (hs[2] !== p0 || hs[3] !== p1) lag++;
            p0 = pwm[0];
            p1 = pwm[1];
        end
        chk("pwm0 high", 16'h000C, 16'(h0));
        chk("pwm1 high", 16'h0010, 16'(h1));
        chk("pwm follow", 16'h0, 16'(lag));
        wr_cfg(4'h1, `CFG_TIMER1);
        wr_cfg(4'h2, `CFG_TIMER2);
        @(posedge clk_i) t1 <= 1'b1;
        tick(2);
        chk("timers a", 16'h1, 16'(hs[1:0]));
        @(posedge clk_i) {t1, t2} <= 2'b01;
        tick(2);
        chk("timers b", 16'h2, 16'(hs[1:0]));
        $display("test_pwm done");
    endtask

    task automatic test_modes();
        wr_cfg(4'h3, `CFG_ON);
        @(posedge clk_i) mode <= MODE_STOP;
        wr_cfg(4'h1, `CFG_OFF);
        chk("stop cfg", 16'h1, 16'(cfg[0]));
        chk("stop on", 16'h3, 16'(hs[1:0]));
        @(posedge clk_i) begin
            mode <= MODE_SLEEP;
            opn <= 4'h1;
        end
        tick(OLF + 2);
        chk("sleep ol", 16'h1, 16'(olf));
        chk("sleep pwm", 16'h4, 16'(cfg[2]));
        // Supply shutdown in sleep drops the drive but keeps the setting
        @(posedge clk_i) sup <= 1'b1;
        tick(2);
        chk("sleep sup off", 16'h0, 16'(hs));
        chk("sleep sup cfg", 16'h1, 16'(cfg[0]));
        @(posedge clk_i) sup <= 1'b0;
        tick(2);
        chk("sleep sup back", 16'h3, 16'(hs[1:0]));
        @(posedge clk_i) mode <= MODE_RESTART;
        tick(2);
        chk("rst off", 16'h0, 16'(hs));
        chk("rst cfg", 16'h0, 16'(cfg));
        @(posedge clk_i) begin
            mode <= MODE_NORMAL;
            opn <= 4'h0;
        end
        wr_cfg(4'h1, `CFG_ON);
        chk("re on", 16'h1, 16'(hs));
        // Fail-safe drops drive and configuration as restart does
        @(posedge clk_i) mode <= MODE_FAILSAFE;
        tick(2);
        chk("fs off", 16'h0, 16'(hs));
        chk("fs cfg", 16'h0, 16'(cfg));
        @(posedge clk_i) mode <= MODE_NORMAL;
        tick(1);
        $display("test_modes done");
    endtask

    task automatic tally_and_finish();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        test_open_load();
        test_overcurrent();
        test_pwm();
        test_modes();
        tally_and_finish();
    end
endmodule
`default_nettype wire
